// *** hdl/dlsc_top.sv ***
// dlsc_top: status and control bank for the dual serial output link and input clock detection.
// assumes link, clock-detect and strap inputs are asynchronous and synchronised here;
// wishbone slave on clk; downstream mode and swap indications come from the link logic.
// Behaviour
// - link ready bit 7 set only once connection found and capabilities learned
// - transmit active bit 6 needs tx running, rx locked, valid input, link ready
// - port mode field reports dual, port0, port1 or both while transmit active
// - in independent mode per-port status bits follow the currently selected output port
// - clock detect bit 3 mirrors the input pll clock detect indication
// - no-clock bit 1 set when rate not above low threshold
// - frequency stable bit 0 follows the detector's stable verdict
// - cable type bit 7 selects pair or coax, loaded from strap b
// - swap bit 6 shows swap state, writable only with auto correction off
// - with bit 5 set a frequency change resets the transmit pll
// - bit 4 picks detector source: raw input clock or pll clock
// - bit 3 aligns odd/even pixels to data enable in dual mode
// - three-bit transmit mode field decodes auto, forced and reserved codes
// - auto settings choose operating mode from attached downstream devices
// - transmit mode loaded from strap a at power-up, 000 or 111
// - disable-swap control stops auto swap correction and unlocks swap bit
// - six-bit low rate threshold in MHz resets to 6
`timescale 1ns/100ps
`default_nettype none
module dlsc_top
    import dlsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [DLSC_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // straps, sampled after reset release
    input wire logic mode_strap_pin_a,
    input wire logic mode_strap_pin_b,
    // link and clock side, per output port
    input wire dlsc_pkg::dlsc_port_t port_stat_i [2],
    input wire dlsc_pkg::dlsc_clk_t clk_stat_i [2],
    input wire logic port_select_i,
    input wire logic [1:0] downstream_found_i,
    input wire logic downstream_dual_i,
    // configuration to the datapath
    output dlsc_pkg::dlsc_cfg_t cfg_o,
    // interrupt
    output logic irq_o
);
    import dlsc_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0][4:0] port_s1;
        logic [1:0][4:0] port_s2;
        logic [1:0][3:0] clk_s1;
        logic [1:0][3:0] clk_s2;
        logic [1:0] misc_s1;
        logic [1:0] misc_s2;
        logic [2:0] found_s1;
        logic [2:0] found_s2;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic strap_done;
        logic [1:0] strap_wait;
        logic coax;
        logic swap_sw;
        logic pll_rst_en;
        logic src_pll;
        logic align;
        logic [2:0] mode;
        logic noswap;
        logic [5:0] low_thr;
        logic [7:0] status;
        logic [DLSC_NIRQ-1:0] irq_sts;
        logic [DLSC_NIRQ-1:0] irq_mask;
        logic pll_reset;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dlsc_state_t;

    dlsc_state_t s_q;
    dlsc_state_t s_d;

    // independent mode shows the selected port, otherwise port 0 drives the bits
    function automatic logic pick(input logic [1:0] v, input logic indep, input logic sel);
        pick = (indep && sel) ? v[1] : v[0];
    endfunction

    logic req;
    logic wr;
    logic [7:0] idx;
    logic indep;
    logic sel;
    logic tx_ok;
    logic [1:0] ports;
    logic rdy;
    logic [7:0] st;
    logic [DLSC_NIRQ-1:0] ev;
    logic [7:0] wbyte;
    logic [1:0] link_found;
    logic [1:0] caps;
    logic [1:0] txr;
    logic [1:0] lock;
    logic [1:0] swp;
    logic [1:0] cdet;
    logic [1:0] above;
    logic [1:0] stbl;
    logic [1:0] chg;

    always_comb
    begin
        s_d = s_q;
        for (int p = 0; p < 2; p++)
        begin
            s_d.port_s1[p] = port_stat_i[p];
            s_d.clk_s1[p] = clk_stat_i[p];
            link_found[p] = s_q.port_s2[p][4];
            caps[p] = s_q.port_s2[p][3];
            txr[p] = s_q.port_s2[p][2];
            lock[p] = s_q.port_s2[p][1];
            swp[p] = s_q.port_s2[p][0];
            cdet[p] = s_q.clk_s2[p][3];
            above[p] = s_q.clk_s2[p][2];
            stbl[p] = s_q.clk_s2[p][1];
            chg[p] = s_q.clk_s2[p][0];
        end
        s_d.port_s2 = s_q.port_s1;
        s_d.clk_s2 = s_q.clk_s1;
        s_d.misc_s1 = {port_select_i, downstream_dual_i};
        s_d.misc_s2 = s_q.misc_s1;
        s_d.found_s1 = {downstream_found_i, 1'b0};
        s_d.found_s2 = s_q.found_s1;
        s_d.strap_s1 = {mode_strap_pin_b, mode_strap_pin_a};
        s_d.strap_s2 = s_q.strap_s1;

        indep = (s_q.mode == DLSC_MODE_INDEP);
        sel = s_q.misc_s2[1];

        // ---------------------------------------------------------------
        // operating mode choice
        // ---------------------------------------------------------------
        unique case (dlsc_mode_t'(s_q.mode))
            DLSC_MODE_AUTO:
                ports = (s_q.found_s2[2:1] == 2'h3) ? (s_q.misc_s2[0] ? DLSC_PORT_DUAL : DLSC_PORT_BOTH)
                      : (s_q.found_s2[2] ? DLSC_PORT_P1 : DLSC_PORT_P0);
            DLSC_MODE_AUTO_NODUAL:
                ports = (s_q.found_s2[2:1] == 2'h3) ? DLSC_PORT_BOTH
                      : (s_q.found_s2[2] ? DLSC_PORT_P1 : DLSC_PORT_P0);
            DLSC_MODE_SINGLE: ports = DLSC_PORT_P0;
            DLSC_MODE_DUAL: ports = DLSC_PORT_DUAL;
            DLSC_MODE_INDEP, DLSC_MODE_SPLIT: ports = DLSC_PORT_BOTH;
            default: ports = DLSC_PORT_P0; // reserved codes: single port, safest
        endcase

        // ---------------------------------------------------------------
        // status image
        // ---------------------------------------------------------------
        rdy = pick(link_found & caps, indep, sel);
        tx_ok = pick(txr & lock & cdet & above, indep, sel) && rdy;
        st = 8'h00;
        st[DLSC_ST_LINK_RDY] = rdy;
        st[DLSC_ST_TX_ACT] = tx_ok;
        st[DLSC_ST_PORT_HI:DLSC_ST_PORT_LO] = tx_ok ? ports : 2'h0;
        st[DLSC_ST_CLK_DET] = pick(cdet, indep, sel);
        st[DLSC_ST_NO_CLK] = !pick(above, indep, sel);
        st[DLSC_ST_STABLE] = pick(stbl, indep, sel);
        s_d.status = st;

        // events: link ready rise, transmit active rise, clock loss, rate change
        ev = {pick(chg, indep, sel),
              st[DLSC_ST_NO_CLK] & !s_q.status[DLSC_ST_NO_CLK],
              tx_ok & !s_q.status[DLSC_ST_TX_ACT],
              rdy & !s_q.status[DLSC_ST_LINK_RDY]};
        s_d.pll_reset = s_q.pll_rst_en && (chg != 2'h0);

        // the synchroniser is cleared by reset, so wait until both stages hold pin levels
        if (!s_q.strap_done)
        begin
            if (s_q.strap_wait == 2'h2)
            begin
                s_d.strap_done = 1'b1;
                s_d.coax = s_q.strap_s2[1];
                s_d.mode = s_q.strap_s2[0] ? DLSC_MODE_SPLIT : DLSC_MODE_AUTO;
            end
            else
                s_d.strap_wait = s_q.strap_wait + 2'h1;
        end

        // ---------------------------------------------------------------
        // wishbone slave
        // ---------------------------------------------------------------
        req = wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err;
        wr = req && wb_we_i && wb_sel_i[0];
        idx = wb_adr_i[DLSC_AW-1:2];
        wbyte = wb_dat_i[7:0];
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.irq_sts = s_q.irq_sts;
        if (req)
        begin
            s_d.rdata = 32'h0000_0000;
            s_d.ack = 1'b1;
            unique case (idx)
                DLSC_IDX_STATUS: s_d.rdata[7:0] = s_q.status;
                DLSC_IDX_CTRL: s_d.rdata[7:0] = {s_q.coax, s_q.noswap ? s_q.swap_sw : swp[0],
                                                 s_q.pll_rst_en, s_q.src_pll, s_q.align, s_q.mode};
                DLSC_IDX_CTRL2: s_d.rdata[7:0] = {s_q.noswap, 7'h00};
                DLSC_IDX_LOWTHR: s_d.rdata[7:0] = {2'h0, s_q.low_thr};
                DLSC_IDX_IRQ_STS: s_d.rdata[DLSC_NIRQ-1:0] = s_q.irq_sts;
                DLSC_IDX_IRQ_MASK: s_d.rdata[DLSC_NIRQ-1:0] = s_q.irq_mask;
                default:
                begin
                    s_d.ack = 1'b0;
                    s_d.err = 1'b1;
                end
            endcase
            if (wr)
            begin
                unique case (idx)
                    DLSC_IDX_CTRL:
                    begin
                        s_d.coax = wbyte[DLSC_CT_COAX];
                        if (s_q.noswap)
                            s_d.swap_sw = wbyte[DLSC_CT_SWAP];
                        s_d.pll_rst_en = wbyte[DLSC_CT_PLLRST];
                        s_d.src_pll = wbyte[DLSC_CT_SRC];
                        s_d.align = wbyte[DLSC_CT_ALIGN];
                        s_d.mode = wbyte[2:0];
                    end
                    DLSC_IDX_CTRL2:
                    begin
                        // latch auto state so disabling correction keeps the current swap
                        if (wbyte[DLSC_C2_NOSWAP] && !s_q.noswap)
                            s_d.swap_sw = swp[0];
                        s_d.noswap = wbyte[DLSC_C2_NOSWAP];
                    end
                    DLSC_IDX_LOWTHR: s_d.low_thr = wbyte[5:0];
                    DLSC_IDX_IRQ_STS: s_d.irq_sts = s_q.irq_sts & ~wbyte[DLSC_NIRQ-1:0];
                    DLSC_IDX_IRQ_MASK: s_d.irq_mask = wbyte[DLSC_NIRQ-1:0];
                    default: ;
                endcase
            end
        end
        // set wins over a clear in the same cycle
        s_d.irq_sts = s_d.irq_sts | ev;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.low_thr <= DLSC_LOWTHR_RST;
        end
        else
            s_q <= s_d;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_comb
    begin
        cfg_o.cable_type_select = s_q.coax;
        cfg_o.swap_active = s_q.noswap ? s_q.swap_sw : pick(swp, indep, sel);
        cfg_o.rate_detect_source_select = s_q.src_pll;
        cfg_o.pixel_align_on_enable = s_q.align && (s_q.status[DLSC_ST_PORT_HI:DLSC_ST_PORT_LO] == DLSC_PORT_DUAL);
        cfg_o.transmit_operating_mode = dlsc_mode_t'(s_q.mode);
        cfg_o.chosen_ports = s_q.status[DLSC_ST_PORT_HI:DLSC_ST_PORT_LO];
        cfg_o.low_rate_threshold = s_q.low_thr;
        cfg_o.pll_reset = s_q.pll_reset;
    end

    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign wb_err_o = s_q.err;
    assign irq_o = |(s_q.irq_sts & s_q.irq_mask);
endmodule // dlsc_top
`default_nettype wire

// *** hdl/dlsc_pkg.sv ***
// dlsc_pkg: offsets, field positions, reset values and carriers for the dual link status/control bank.
// assumes a classic wishbone slave with 32-bit data, one register per aligned word.
package dlsc_pkg;
    // ---------------------------------------------------------------
    // register indices and address width
    // ---------------------------------------------------------------
    localparam logic [7:0] DLSC_IDX_STATUS = 8'h5A;
    localparam logic [7:0] DLSC_IDX_CTRL = 8'h5B;
    localparam logic [7:0] DLSC_IDX_CTRL2 = 8'h5C;
    localparam logic [7:0] DLSC_IDX_LOWTHR = 8'h5D;
    localparam logic [7:0] DLSC_IDX_IRQ_STS = 8'h60;
    localparam logic [7:0] DLSC_IDX_IRQ_MASK = 8'h61;
    localparam int DLSC_AW = 10;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int DLSC_ST_LINK_RDY = 7;
    localparam int DLSC_ST_TX_ACT = 6;
    localparam int DLSC_ST_PORT_HI = 5;
    localparam int DLSC_ST_PORT_LO = 4;
    localparam int DLSC_ST_CLK_DET = 3;
    localparam int DLSC_ST_NO_CLK = 1;
    localparam int DLSC_ST_STABLE = 0;
    localparam int DLSC_CT_COAX = 7;
    localparam int DLSC_CT_SWAP = 6;
    localparam int DLSC_CT_PLLRST = 5;
    localparam int DLSC_CT_SRC = 4;
    localparam int DLSC_CT_ALIGN = 3;
    localparam int DLSC_C2_NOSWAP = 7;
    // ---------------------------------------------------------------
    // reset values and encodings
    // ---------------------------------------------------------------
    localparam logic [5:0] DLSC_LOWTHR_RST = 6'h06;
    localparam logic [1:0] DLSC_PORT_DUAL = 2'h0;
    localparam logic [1:0] DLSC_PORT_P0 = 2'h1;
    localparam logic [1:0] DLSC_PORT_P1 = 2'h2;
    localparam logic [1:0] DLSC_PORT_BOTH = 2'h3;
    localparam int DLSC_NIRQ = 4;

    typedef enum logic [2:0] {
        DLSC_MODE_AUTO = 3'h0,
        DLSC_MODE_SINGLE = 3'h1,
        DLSC_MODE_RSV2 = 3'h2,
        DLSC_MODE_DUAL = 3'h3,
        DLSC_MODE_AUTO_NODUAL = 3'h4,
        DLSC_MODE_INDEP = 3'h5,
        DLSC_MODE_RSV6 = 3'h6,
        DLSC_MODE_SPLIT = 3'h7
    } dlsc_mode_t;

    // link-side status from one output port
    typedef struct packed {
        logic link_found;
        logic caps_known;
        logic tx_running;
        logic rx_locked;
        logic swapped;
    } dlsc_port_t;

    // input clock side indications for one port
    typedef struct packed {
        logic pll_clk_det;
        logic rate_above_low;
        logic rate_stable;
        logic rate_change;
    } dlsc_clk_t;

    // what the block tells the datapath
    typedef struct packed {
        logic cable_type_select;
        logic swap_active;
        logic rate_detect_source_select;
        logic pixel_align_on_enable;
        dlsc_mode_t transmit_operating_mode;
        logic [1:0] chosen_ports;
        logic [5:0] low_rate_threshold;
        logic pll_reset;
    } dlsc_cfg_t;
endpackage

// *** testbench/dlsc_top_assertions.sv ***
// dlsc_top_assertions: port-level checks on dlsc_top, bound below.
// assumes one clk domain with async active-low rst_n.
`timescale 1ns/100ps
`default_nettype none
module dlsc_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dlsc_pkg::DLSC_AW-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // clock side and config
    input wire dlsc_pkg::dlsc_clk_t clk_stat_i [2],
    input wire dlsc_pkg::dlsc_cfg_t cfg_o
);
    import dlsc_pkg::*;
    logic tk;
    logic rc;
    logic mp;
    logic [7:0] ix;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign ix = wb_adr_i[9:2];
    assign rc = clk_stat_i[0].rate_change || clk_stat_i[1].rate_change;
    assign mp = ix inside {DLSC_IDX_STATUS, DLSC_IDX_CTRL, DLSC_IDX_CTRL2, DLSC_IDX_LOWTHR,
        DLSC_IDX_IRQ_STS, DLSC_IDX_IRQ_MASK};
    a_ack_latency: assert property (tk |=> (wb_ack_o || wb_err_o))
        else $error("no answer one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    a_err_unmapped: assert property (tk && !mp |=> wb_err_o && !wb_ack_o)
        else $error("unmapped index not refused");
    a_status_zero_bits: assert property (tk && !wb_we_i && ix == DLSC_IDX_STATUS |=>
        wb_dat_o[2] == 1'b0 && wb_dat_o[31:8] == 24'h000000) else $error("status spare bits set");
    // pll reset may only follow a recent rate change, sync delay included
    a_pll_reset_cause: assert property (cfg_o.pll_reset |->
        (rc || $past(rc) || $past(rc, 2) || $past(rc, 3) || $past(rc, 4))) else $error("pll reset uncaused");
    a_thr_reset: assert property ($rose(rst_n) |-> cfg_o.low_rate_threshold == DLSC_LOWTHR_RST)
        else $error("low threshold not 6 after reset");
    // strap load lands on the third edge after release, so changes are excused until then
    a_mode_by_write: assert property (($changed({cfg_o.cable_type_select, cfg_o.transmit_operating_mode})
        && $past(rst_n, 4)) |-> wb_ack_o) else $error("mode changed without write");
    c_write: cover property (tk && wb_we_i);
    c_err: cover property (wb_err_o);
    c_pll: cover property (cfg_o.pll_reset);
endmodule // dlsc_chk
bind dlsc_top dlsc_chk u_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .clk_stat_i(clk_stat_i), .cfg_o(cfg_o));
`default_nettype wire

// *** testbench/dlsc_link_model.sv ***
// dlsc_link_model: downstream receiver on port 0 and input clock detector.
// assumes level commands from the bench on clk; port 1 has no device.
`timescale 1ns/100ps
`default_nettype none
module dlsc_link_model
(
    // clock and commands
    input wire logic clk,
    input wire logic link_up,
    input wire logic clk_ok,
    input wire logic rate_chg,
    // towards the bank
    output var dlsc_pkg::dlsc_port_t port_stat_o [2],
    output var dlsc_pkg::dlsc_clk_t clk_stat_o [2],
    output var logic [1:0] found_o,
    output var logic dual_o
);
    import dlsc_pkg::*;
    dlsc_port_t p0_q = '0;
    // capabilities only after a device answered, lock only after that
    always @(posedge clk)
    begin
        p0_q.link_found <= link_up;
        p0_q.caps_known <= link_up && p0_q.link_found;
        p0_q.tx_running <= link_up && p0_q.caps_known && clk_ok;
        p0_q.rx_locked <= link_up && p0_q.tx_running;
        p0_q.swapped <= 1'b0;
    end
    assign port_stat_o[0] = p0_q;
    assign port_stat_o[1] = '0;
    assign clk_stat_o[0] = {clk_ok, clk_ok, clk_ok, rate_chg};
    assign clk_stat_o[1] = '0;
    assign found_o = {1'b0, p0_q.link_found};
    assign dual_o = 1'b0;
endmodule // dlsc_link_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// tb_top: register-level bench for dlsc_top with the link model on port 0.
// assumes ack one cycle after request and status three cycles behind inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dlsc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [DLSC_AW-1:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic ack;
    logic err;
    logic got_err;
    logic irq;
    logic link_up = 1'b0;
    logic clk_ok = 1'b0;
    logic rate_chg = 1'b0;
    logic psel = 1'b0;
    logic dual;
    logic [1:0] found;
    dlsc_port_t pst [2];
    dlsc_clk_t cst [2];
    dlsc_cfg_t cfg;
    int failures = 0;
    int check_count = 0;
    initial
    begin
        forever #2 clk = ~clk;
    end
    dlsc_top uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .mode_strap_pin_a(1'b1), .mode_strap_pin_b(1'b1), .port_stat_i(pst), .clk_stat_i(cst),
        .port_select_i(psel), .downstream_found_i(found), .downstream_dual_i(dual), .cfg_o(cfg), .irq_o(irq));
    dlsc_link_model u_link (.clk(clk), .link_up(link_up), .clk_ok(clk_ok), .rate_chg(rate_chg),
        .port_stat_o(pst), .clk_stat_o(cst), .found_o(found), .dual_o(dual));
    task automatic close_out();
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        check_count++;
        if (sn !== ex)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    // ack is sampled at the rising edge; the request drops at that same edge
    task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        wdat <= {24'h000000, d};
        do
            @(posedge clk);
        while (ack !== 1'b1 && err !== 1'b1 && ++n < 50);
        if (ack !== 1'b1 && err !== 1'b1)
        begin
            failures++;
            close_out();
        end
        else
        begin
            got = rdat;
            got_err = err;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] ix, input logic [31:0] m, input logic [31:0] ex);
        xfer(1'b0, ix, 8'h00);
        chk(nm, ex, got & m);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd("ctrl strap", DLSC_IDX_CTRL, 32'hFFFFFFFF, 32'h00000087);
        // port field is held at zero while transmit is idle
        rd("status idle", DLSC_IDX_STATUS, 32'hFFFFFFCF, 32'h00000002);
        rd("status again", DLSC_IDX_STATUS, 32'hFFFFFFCF, 32'h00000002);
        rd("low thr", DLSC_IDX_LOWTHR, 32'h0000003F, 32'h00000006);
        xfer(1'b0, 8'h70, 8'h00);
        chk("unmapped err", 32'h00000001, {31'h0, got_err});
        xfer(1'b1, DLSC_IDX_CTRL, 8'h61);
        rd("swap locked", DLSC_IDX_CTRL, 32'h000000FF, 32'h00000021);
        xfer(1'b1, DLSC_IDX_CTRL2, 8'h80);
        xfer(1'b1, DLSC_IDX_CTRL, 8'h61);
        rd("swap free", DLSC_IDX_CTRL, 32'h000000FF, 32'h00000061);
        xfer(1'b1, DLSC_IDX_CTRL2, 8'h00);
        for (int m = 0; m < 8; m++)
        begin
            xfer(1'b1, DLSC_IDX_CTRL, {5'h04, m[2:0]});
            @(negedge clk);
            chk("mode", {29'h0, m[2:0]}, {29'h0, cfg.transmit_operating_mode});
        end
        for (int e = 1; e >= 0; e--)
        begin
            xfer(1'b1, DLSC_IDX_CTRL, {2'h0, e[0], 5'h11});
            @(posedge clk);
            rate_chg <= 1'b1;
            repeat (4) @(negedge clk);
            chk("pll reset", {31'h0, e[0]}, {31'h0, cfg.pll_reset});
            @(posedge clk);
            rate_chg <= 1'b0;
            repeat (6) @(posedge clk);
        end
        chk("coax src", 32'h00000001, {30'h0, cfg.cable_type_select, cfg.rate_detect_source_select});
        link_up <= 1'b1;
        clk_ok <= 1'b1;
        repeat (10) @(posedge clk);
        rd("status live", DLSC_IDX_STATUS, 32'h000000FF, 32'h000000D9);
        rd("irq rise", DLSC_IDX_IRQ_STS, 32'h00000003, 32'h00000003);
        chk("irq masked", 32'h00000000, {31'h0, irq});
        xfer(1'b1, DLSC_IDX_IRQ_MASK, 8'h01);
        @(negedge clk);
        chk("irq on", 32'h00000001, {31'h0, irq});
        xfer(1'b1, DLSC_IDX_IRQ_STS, 8'h0F);
        @(negedge clk);
        chk("irq clear", 32'h00000000, {31'h0, irq});
        clk_ok <= 1'b0;
        xfer(1'b1, DLSC_IDX_CTRL, 8'h15);
        psel <= 1'b1;
        repeat (5) @(posedge clk);
        rd("port 1 sel", DLSC_IDX_STATUS, 32'h00000080, 32'h00000000);
        psel <= 1'b0;
        repeat (5) @(posedge clk);
        rd("port 0 sel", DLSC_IDX_STATUS, 32'h00000080, 32'h00000080);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
